// [include/uacp_pkg.sv]
package uacp_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;      // 125 MHz system clock
  localparam int unsigned RST_MIN_NS = 40;        // Shortest pin reset pulse
  // Least time rounds up to whole cycles
  localparam int unsigned RST_MIN_CYC =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] RST_MIN_CNT = 3'(RST_MIN_CYC);

  // ------------------------------------------------------------
  // Serial rate limits, in Kbps
  // ------------------------------------------------------------
  localparam logic [10:0] RATE_HIGH_KBPS = 11'h3E8;  // 1000 Kbps
  localparam logic [10:0] RATE_LOW_KBPS = 11'h0FA;   // 250 Kbps

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int unsigned CTRL_ISO_BIT = 0;   // Software bus isolation
  localparam int unsigned CTRL_RST_BIT = 1;   // Software core reset
  localparam int unsigned ST_STYLE_BIT = 0;
  localparam int unsigned ST_ISO_BIT = 1;
  localparam int unsigned ST_PUMP_BIT = 2;
  localparam int unsigned ST_RXSEL_BIT = 3;
  localparam int unsigned ST_FAST_BIT = 4;
  localparam int unsigned ST_RST_BIT = 5;
  localparam int unsigned ST_IRQOE_BIT = 6;
  localparam int unsigned ST_RATE_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } uacp_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uacp_axi_rsp_type;

  // Strap and control pins, all asynchronous to sys_clk
  typedef struct packed {
    logic bus_style_select;     // High: strobe style, low: direction style
    logic reset_pin;            // Polarity follows bus_style_select
    logic bus_isolate_request;
    logic pump_autosleep;
    logic rx_source_select;
    logic logic_level_rx_input;
    logic line_level_rx_input;
    logic high_rate_select;
  } uacp_pin_type;

  // Host bus pins as they arrive
  typedef struct packed {
    logic cs_n;
    logic rd_n;                 // Read strobe (strobe style only)
    logic wr_n_or_dir;          // Write strobe, or read-high direction
    logic [2:0] addr;
    logic [7:0] data;
  } uacp_host_bus_type;

  // Host bus as handed to the UART core
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] data;
  } uacp_core_bus_type;

  localparam uacp_core_bus_type CORE_BUS_IDLE = '0;

endpackage

// [design/uacp_pin_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// - High style pin selects strobe bus, else direction
// - Reset pin polarity follows bus style
// - Reset of 40 ns resets core outputs
// - During reset transmit high, receive ignored
// - Power-save request isolates host data bus
// - Autosleep stops pump only when oscillator stopped
// - Receive source select picks logic or line
// - High-rate select gives 1 Mbps, else 250
// - Oscillator input buffered out for others
// - Channel B interrupt driven when strobe and enabled
module uacp_pin_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire uacp_pkg::uacp_axi_req_type axi_req,
  output uacp_pkg::uacp_axi_rsp_type axi_rsp,
  input wire uacp_pkg::uacp_pin_type pins,
  input wire uacp_pkg::uacp_host_bus_type host_bus,
  output uacp_pkg::uacp_core_bus_type core_bus,
  input wire logic core_tx,
  input wire logic osc_stopped,
  input wire logic modem_control_irq_en,
  input wire logic core_irq_b,
  input wire logic osc_input,
  output logic osc_buffered_output,
  output logic core_reset,
  output logic uart_tx_out,
  output logic core_rx,
  output logic pump_off,
  output logic high_rate_mode,
  output logic channel_b_irq_o,
  output logic channel_b_irq_oe
);
  import uacp_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  uacp_pin_type pins_meta_q;        // First stage, read by second only
  uacp_pin_type pins_s;             // Safe to use
  uacp_host_bus_type host_meta_q;   // First stage for host bus
  uacp_host_bus_type host_s;

  // Two flops on every strap, control and host bus pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_meta_q <= '0;
      pins_s <= '0;
      host_meta_q <= '1;
      host_s <= '1;
    end else begin
      pins_meta_q <= pins;
      pins_s <= pins_meta_q;
      host_meta_q <= host_bus;
      host_s <= host_meta_q;
    end
  end

  // Oscillator copy goes straight through; a flop would halve it
  assign osc_buffered_output = osc_input;

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;      // Control word
  logic iso_act;                    // Bus isolation in force
  logic pin_rst_act;                // Reset pin at its active level

  assign iso_act = pins_s.bus_isolate_request | ctrl_q[CTRL_ISO_BIT];
  // Polarity chosen by the bus style strap
  assign pin_rst_act = pins_s.bus_style_select ? pins_s.reset_pin
                                               : ~pins_s.reset_pin;

  // ------------------------------------------------------------
  // Reset pulse qualifier
  // ------------------------------------------------------------
  logic [2:0] rst_cnt_q, rst_cnt_d;  // Consecutive active samples
  logic core_reset_q, core_reset_d;

  // Glitches shorter than the minimum pulse never reach the core
  always_comb begin
    rst_cnt_d = '0;
    if (pin_rst_act) begin
      rst_cnt_d = (rst_cnt_q == RST_MIN_CNT) ? rst_cnt_q
                                             : rst_cnt_q + 3'h1;
    end
    core_reset_d = (rst_cnt_d == RST_MIN_CNT)
                 | ctrl_q[CTRL_RST_BIT];
  end

  // Core reset stays asserted through system reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_cnt_q <= '0;
      core_reset_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      core_reset_q <= core_reset_d;
    end
  end

  // ------------------------------------------------------------
  // Serial pins, pump, rate, interrupt and host bus
  // ------------------------------------------------------------
  logic tx_q, tx_d;
  logic rx_q, rx_d;
  logic pump_q, pump_d;
  logic rate_q, rate_d;
  logic irq_o_q, irq_o_d;
  logic irq_oe_q, irq_oe_d;
  uacp_core_bus_type cbus_q, cbus_d;

  always_comb begin
    // Transmit forced to idle high while in reset
    tx_d = core_reset_d ? 1'b1 : core_tx;
    // Receive source choice, idle while reset
    if (core_reset_d) begin
      rx_d = 1'b1;
    end else if (pins_s.rx_source_select) begin
      rx_d = pins_s.logic_level_rx_input;
    end else begin
      rx_d = pins_s.line_level_rx_input;
    end
    pump_d = pins_s.pump_autosleep & osc_stopped;
    rate_d = pins_s.high_rate_select;
    // Open-drain style output, only meaningful on strobe bus
    irq_oe_d = pins_s.bus_style_select & modem_control_irq_en;
    irq_o_d = core_irq_b;
    // Host bus decode; frozen while isolated so nothing toggles
    cbus_d = cbus_q;
    if (iso_act) begin
      cbus_d.cs = 1'b0;
      cbus_d.rd = 1'b0;
      cbus_d.wr = 1'b0;
    end else begin
      cbus_d.cs = ~host_s.cs_n;
      cbus_d.addr = host_s.addr;
      cbus_d.data = host_s.data;
      if (pins_s.bus_style_select) begin
        cbus_d.rd = ~host_s.cs_n & ~host_s.rd_n;
        cbus_d.wr = ~host_s.cs_n & ~host_s.wr_n_or_dir;
      end else begin
        cbus_d.rd = ~host_s.cs_n & host_s.wr_n_or_dir;
        cbus_d.wr = ~host_s.cs_n & ~host_s.wr_n_or_dir;
      end
    end
  end

  // Outputs register here, reset to quiet levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_q <= 1'b1;
      rx_q <= 1'b1;
      pump_q <= 1'b0;
      rate_q <= 1'b0;
      irq_o_q <= 1'b0;
      irq_oe_q <= 1'b0;
      cbus_q <= CORE_BUS_IDLE;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      pump_q <= pump_d;
      rate_q <= rate_d;
      irq_o_q <= irq_o_d;
      irq_oe_q <= irq_oe_d;
      cbus_q <= cbus_d;
    end
  end

  assign core_reset = core_reset_q;
  assign uart_tx_out = tx_q;
  assign core_rx = rx_q;
  assign pump_off = pump_q;
  assign high_rate_mode = rate_q;
  assign channel_b_irq_o = irq_o_q;
  assign channel_b_irq_oe = irq_oe_q;
  assign core_bus = cbus_q;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic aw_have_q, aw_have_d;       // Write address held
  logic [31:0] aw_addr_q, aw_addr_d;
  logic w_have_q, w_have_d;         // Write data held
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] status;              // Live block state

  always_comb begin
    status = '0;
    status[ST_STYLE_BIT] = pins_s.bus_style_select;
    status[ST_ISO_BIT] = iso_act;
    status[ST_PUMP_BIT] = pump_q;
    status[ST_RXSEL_BIT] = pins_s.rx_source_select;
    status[ST_FAST_BIT] = rate_q;
    status[ST_RST_BIT] = core_reset_q;
    status[ST_IRQOE_BIT] = irq_oe_q;
    status[ST_RATE_LSB +: 11] = rate_q ? RATE_HIGH_KBPS
                                       : RATE_LOW_KBPS;
  end

  // Address and data may come in either order; one write at a time
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (axi_req.awvalid && axi_rsp.awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      w_have_d = 1'b1;
      w_data_d = axi_req.wdata;
      w_strb_d = axi_req.wstrb;
    end
    if (aw_have_q && w_have_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      if (aw_addr_q == CTRL_OFS) begin
        bresp_d = RESP_OKAY;
        if (w_strb_q[0]) begin
          ctrl_d[7:0] = w_data_q[7:0];
        end
      end else if (aw_addr_q == STAT_OFS) begin
        bresp_d = RESP_OKAY;  // Read-only, write dropped
      end else begin
        bresp_d = RESP_SLVERR;
      end
    end
    if (bvalid_q && axi_req.bready) begin
      bvalid_d = 1'b0;
    end
    // Read answers one cycle after the address is taken
    if (axi_req.arvalid && axi_rsp.arready) begin
      rvalid_d = 1'b1;
      if (axi_req.araddr == CTRL_OFS) begin
        rdata_d = ctrl_q;
        rresp_d = RESP_OKAY;
      end else if (axi_req.araddr == STAT_OFS) begin
        rdata_d = status;
        rresp_d = RESP_OKAY;
      end else begin
        rdata_d = '0;
        rresp_d = RESP_SLVERR;
      end
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Handshake outputs from held flags
  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = ~aw_have_q & ~bvalid_q;
    axi_rsp.wready = ~w_have_q & ~bvalid_q;
    axi_rsp.bvalid = bvalid_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.arready = ~rvalid_q;
    axi_rsp.rvalid = rvalid_q;
    axi_rsp.rdata = rdata_q;
    axi_rsp.rresp = rresp_q;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_strobe_read_decode: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pins_s.bus_style_select && !host_s.cs_n && !host_s.rd_n && !iso_act)
    |=> core_bus.rd)
    else $error("strobe style read not decoded");

  a_reset_high_pol: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pins_s.bus_style_select && pins_s.reset_pin) [*5] |=> core_reset)
    else $error("high reset pin ignored on strobe bus");

  a_reset_low_pol: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!pins_s.bus_style_select && !pins_s.reset_pin) [*5] |=> core_reset)
    else $error("low reset pin ignored on direction bus");

  a_reset_tx_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    core_reset |-> (uart_tx_out && core_rx))
    else $error("serial pins not idle in reset");

  a_iso_no_strobe: assert property (
    @(posedge sys_clk) disable iff (rst)
    iso_act |=> (!core_bus.cs && !core_bus.rd && !core_bus.wr))
    else $error("strobe passed during isolation");

  a_iso_bus_frozen: assert property (
    @(posedge sys_clk) disable iff (rst)
    iso_act |=> ($stable(core_bus.addr) && $stable(core_bus.data)))
    else $error("bus moved during isolation");

  a_pump_off_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pins_s.pump_autosleep && osc_stopped) ##1 1'b1 |-> pump_off)
    else $error("pump not shut off");

  a_pump_needs_sleep: assert property (
    @(posedge sys_clk) disable iff (rst)
    pump_off |-> $past(osc_stopped))
    else $error("pump off without stopped oscillator");

  a_rx_logic_pick: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!core_reset_d && pins_s.rx_source_select)
    |=> (core_rx == $past(pins_s.logic_level_rx_input)))
    else $error("wrong receive source");

  a_rate_limit: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 (high_rate_mode == $past(pins_s.high_rate_select)))
    else $error("rate select not followed");

  a_irq_enable_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    channel_b_irq_oe |-> $past(pins_s.bus_style_select
                               && modem_control_irq_en))
    else $error("interrupt driven while disabled");

endmodule

// [tb/uacp_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host processor on the 8-bit parallel bus
// ------------------------------------------------------------
module uacp_host_model (
  input wire logic sys_clk,
  input wire logic style,
  output uacp_pkg::uacp_host_bus_type host_bus
);
  import uacp_pkg::*;
  // Idle: deselected, strobes high
  initial host_bus = {3'b111, 11'h000};
  // Start one access; kept until release_bus
  task automatic drive(input logic wr, input logic [2:0] a,
                       input logic [7:0] d);
    @(posedge sys_clk);
    host_bus.cs_n <= 1'b0;
    host_bus.rd_n <= style ? wr : 1'b1;
    host_bus.wr_n_or_dir <= !wr;
    host_bus.addr <= a;
    host_bus.data <= d;
  endtask
  // Released lines show the inverse, never a stale copy
  task automatic release_bus();
    @(posedge sys_clk);
    host_bus.cs_n <= 1'b1;
    host_bus.rd_n <= 1'b1;
    host_bus.wr_n_or_dir <= 1'b1;
    host_bus.addr <= ~host_bus.addr;
    host_bus.data <= ~host_bus.data;
  endtask
endmodule

// [tb/uacp_pin_ctrl_bench.sv]
`timescale 1ns/1ps
module uacp_pin_ctrl_bench;
  import uacp_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  uacp_axi_req_type req = '0;
  uacp_axi_rsp_type rsp;
  uacp_pin_type pins = 8'h80; // Strobe style, reset inactive
  uacp_host_bus_type hb;
  uacp_core_bus_type cb;
  logic core_tx = 1'b1;
  logic osc_stopped = 1'b0;
  logic irq_en = 1'b0;
  logic irq_b = 1'b0;
  logic osc_in = 1'b0;
  logic osc_out, core_reset, tx_out, core_rx, pump_off, fast, irq_o, irq_oe;
  logic [31:0] rd;
  logic [1:0] resp;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  always #4 sys_clk = ~sys_clk;

  uacp_pin_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .axi_req(req),
    .axi_rsp(rsp), .pins(pins), .host_bus(hb), .core_bus(cb),
    .core_tx(core_tx), .osc_stopped(osc_stopped),
    .modem_control_irq_en(irq_en), .core_irq_b(irq_b), .osc_input(osc_in),
    .osc_buffered_output(osc_out), .core_reset(core_reset),
    .uart_tx_out(tx_out), .core_rx(core_rx), .pump_off(pump_off),
    .high_rate_mode(fast), .channel_b_irq_o(irq_o),
    .channel_b_irq_oe(irq_oe));

  uacp_host_model u_host (.sys_clk(sys_clk),
    .style(pins.bus_style_select), .host_bus(hb));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Sample 1 ns after the edge so flop updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [31:0] a);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Reset pin kept inactive for the chosen style
  task automatic set_style(input logic s);
    @(posedge sys_clk);
    pins.bus_style_select <= s;
    pins.reset_pin <= !s;
    step(5);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_axi();
    axi_rd(CTRL_OFS);
    check(rd, CTRL_RESET);
    axi_wr(CTRL_OFS, 32'hFFFF_FFFC);
    check(resp, RESP_OKAY);
    axi_rd(CTRL_OFS);
    check(rd, 32'h0000_00FC);
    axi_wr(32'h0000_0010, 32'h0000_0001);
    check(resp, RESP_SLVERR);
    axi_rd(32'h0000_0010);
    check(rd, 32'h0000_0000);
    check(resp, RESP_SLVERR);
    axi_wr(STAT_OFS, 32'h0000_0000);
    check(resp, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h0000_0002);
    step(2);
    check({core_reset, tx_out}, 2'b11);
    axi_rd(STAT_OFS);
    check(rd[ST_RATE_LSB +: 11], RATE_LOW_KBPS);
    axi_wr(CTRL_OFS, 32'h0000_0000);
    step(2);
    check(core_reset, 1'b0);
    $display("axi test finished");
  endtask

  // Both bus styles, read then write
  task automatic t_host();
    for (int i = 0; i < 4; i++) begin
      set_style(i[1]);
      u_host.drive(i[0], 3'(i + 3), 8'(8'hA0 + i));
      step(5);
      check({cb.cs, cb.rd, cb.wr, cb.addr},
            {1'b1, !i[0], i[0], 3'(i + 3)});
      if (i[0]) check(cb.data, 8'hA0 + i);
      u_host.release_bus();
      step(5);
      check({cb.cs, cb.rd, cb.wr}, 3'b000);
    end
    $display("host bus test finished");
  endtask

  // Pin isolation, then software isolation
  task automatic t_iso();
    u_host.drive(1'b1, 3'h1, 8'h5A);
    u_host.release_bus();
    @(posedge sys_clk);
    pins.bus_isolate_request <= 1'b1;
    step(4);
    u_host.drive(1'b1, 3'h3, 8'h77);
    step(5);
    check(cb, {3'b000, 3'h6, 8'hA5});
    @(posedge sys_clk);
    pins.bus_isolate_request <= 1'b0;
    step(5);
    check({cb.cs, cb.wr, cb.addr}, 5'b11011);
    axi_wr(CTRL_OFS, 32'h0000_0001);
    step(2);
    check({cb.cs, cb.rd, cb.wr}, 3'b000);
    axi_rd(STAT_OFS);
    check(rd[ST_ISO_BIT], 1'b1);
    axi_wr(CTRL_OFS, 32'h0000_0000);
    u_host.release_bus();
    $display("isolation test finished");
  endtask

  // Four samples ignored, a long pulse resets; polarity per style
  task automatic t_rst(input logic s);
    set_style(s);
    @(posedge sys_clk);
    core_tx <= 1'b0;
    pins.reset_pin <= s;
    repeat (4) @(posedge sys_clk);
    pins.reset_pin <= !s;
    for (int i = 0; i < 10; i++) begin
      step(1);
      check(core_reset, 1'b0);
    end
    @(posedge sys_clk);
    pins.reset_pin <= s;
    step(12);
    check({core_reset, tx_out, core_rx}, 3'b111);
    @(posedge sys_clk);
    pins.reset_pin <= !s;
    step(6);
    check({core_reset, tx_out, core_rx}, 3'b000);
    @(posedge sys_clk);
    core_tx <= 1'b1;
    $display("reset pin test finished");
  endtask

  task automatic t_pins();
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      pins.rx_source_select <= i[1];
      pins.logic_level_rx_input <= i[0];
      pins.line_level_rx_input <= !i[0];
      pins.high_rate_select <= i[0];
      pins.pump_autosleep <= i[1];
      osc_stopped <= i[2];
      osc_in <= i[0];
      #1;
      check(osc_out, i[0]);
      step(4);
      check(core_rx, i[1] ? i[0] : !i[0]);
      check({fast, pump_off}, {i[0], i[1] & i[2]});
    end
    axi_rd(STAT_OFS);
    check(rd[ST_RATE_LSB +: 11], RATE_HIGH_KBPS);
    $display("pin test finished");
  endtask

  task automatic t_irq();
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      pins.bus_style_select <= i[0];
      pins.reset_pin <= !i[0];
      irq_en <= i[1];
      irq_b <= i[2];
      step(5);
      check(irq_oe, i[0] & i[1]);
      if (i[0] & i[1]) check(irq_o, i[2]);
    end
    $display("interrupt test finished");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    step(10);
    check({core_reset, tx_out}, 2'b11);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    step(6);
    t_axi();
    t_host();
    set_style(1'b1);
    t_iso();
    t_rst(1'b1);
    t_rst(1'b0);
    t_pins();
    t_irq();
    complete_run();
  end
endmodule
